// ===== rtl/sof_map.vh
// Purpose: constants for the stack operand formatter
// Assumes: one core clock, synchronous active-low reset
// Notes: type codes are sent by the execution unit with each request
//
// Overview of operation
// - the result stack holds eight layers, layer zero is the top
// - each load pushes layers up by one (narrow four-byte: by two), deepest is lost, new enters top
// - narrow variant has 16-bit layers, four-byte types use a layer pair
// - narrow variant bit load fills top layer with the bit, 0 or 65535
// - narrow variant bit store writes the OR of all top layer bits
// - narrow variant byte load fills low byte, clears upper byte
// - narrow variant byte store writes only the low byte of the top
// - narrow variant word load: lower register low byte, higher one upper
// - narrow variant word store: low byte to lower register, upper higher
// - narrow four-byte load fills layers zero and one in byte order
// - narrow four-byte store writes the top pair to four registers
// - single float is a four-byte value, sign, 8-bit exponent, mantissa
// - patterns 7F800000 and FF800000 flag positive and negative overflow
// - signed narrow loads zero-fill and never sign-extend
// - wide variant has 32-bit layers, no layer pairing here
// - wide variant bit load fills all 32 bits with the bit
// - wide variant bit store writes one when any top bit is set
// - wide variant byte load fills lowest byte, clears the other three
// - wide variant byte store writes only the lowest byte
// - wide variant word load fills lower half, clears upper half
// - wide variant word store writes only the lower half, low byte first
`ifndef SOF_MAP_VH
`define SOF_MAP_VH

// stack geometry
`define SOF_DEPTH      8
`define SOF_W_NARROW   16
`define SOF_W_WIDE     32

// operand type codes
`define SOF_T_BOOL     3'h0
`define SOF_T_BYTE     3'h1
`define SOF_T_WORD     3'h2
`define SOF_T_DWORD    3'h3
`define SOF_T_REAL     3'h4

// byte counts per type
`define SOF_N_ONE      3'h1
`define SOF_N_TWO      3'h2
`define SOF_N_FOUR     3'h4

// overflow patterns of a single float
`define SOF_POS_INF    32'h7F800000
`define SOF_NEG_INF    32'hFF800000

`endif

// ===== rtl/sof_load_pack.v
// Purpose: shape gathered scratchpad bytes into new stack layers
// Assumes: gathered bytes sit in ascending register order, lowest first
// Notes: purely combinational; the caller registers the result
`timescale 1ns/1ps
`include "sof_map.vh"

module sof_load_pack #(
   parameter WIDE = 0
) (
   input  wire [2:0]                  opType,
   input  wire [31:0]                 gathered,
   input  wire                        bitVal,
   output reg  [(WIDE ? 32 : 16)-1:0] newLow,
   output reg  [(WIDE ? 32 : 16)-1:0] newHigh,
   output reg                         pushTwo
);

   localparam LW = WIDE ? `SOF_W_WIDE : `SOF_W_NARROW;

   // zero fill for byte and word loads: no sign extension for signed types
   always @* begin
      newLow  = {LW{1'b0}};
      newHigh = {LW{1'b0}};
      pushTwo = 1'b0;
      case (opType)
         `SOF_T_BOOL: begin
            newLow = {LW{bitVal}};
         end
         `SOF_T_BYTE: begin
            newLow[7:0] = gathered[7:0];
         end
         `SOF_T_WORD: begin
            newLow[15:0] = gathered[15:0];
         end
         `SOF_T_DWORD, `SOF_T_REAL: begin
            if (WIDE) begin
               newLow = gathered[LW-1:0];
            end else begin
               newLow  = gathered[LW-1:0];
               newHigh = gathered[31:32-LW];
               pushTwo = 1'b1;
            end
         end
         default: begin
            pushTwo = 1'b0;
         end
      endcase
   end

endmodule

// ===== rtl/sof_formatter.v
// Purpose: load and store formatting between scratchpad and result stack
// Assumes: scratchpad read data returns one cycle after the read strobe
// Notes: one request at a time; loads push, stores leave the stack alone
`timescale 1ns/1ps
`include "sof_map.vh"

module sof_formatter #(
   parameter WIDE = 0
) (
   input  wire                        mclk,
   input  wire                        nrst,
   input  wire                        reqValid,
   input  wire                        reqStore,
   input  wire [2:0]                  reqType,
   input  wire [15:0]                 reqBase,
   input  wire [2:0]                  reqBit,
   output wire                        reqReady,
   output reg                         reqDone,
   output reg                         reqBadType,
   output reg  [15:0]                 spAddr,
   output reg                         spRdEn,
   input  wire [7:0]                  spRdData,
   output reg                         spWrEn,
   output reg  [7:0]                  spWrData,
   output reg  [7:0]                  spWrMask,
   output wire [(WIDE ? 32 : 16)-1:0] stackTopLayer,
   output wire [(WIDE ? 32 : 16)-1:0] secondStackLayer,
   output wire [(WIDE ? 32 : 16)-1:0] deepestStackLayer,
   output wire [31:0]                 topDoubleLayer,
   output reg                         topPosInf,
   output reg                         topNegInf
);

   localparam LW = WIDE ? `SOF_W_WIDE : `SOF_W_NARROW;
   localparam SW = LW * `SOF_DEPTH;

   // sequencer states
   localparam ST_IDLE = 3'h0;
   localparam ST_RD   = 3'h1;
   localparam ST_LAST = 3'h2;
   localparam ST_PUSH = 3'h3;
   localparam ST_WR   = 3'h4;

   // load walk, one byte per cycle:
   //   accept edge : request latched, first read strobe launched
   //   RD cycles   : one strobe per byte, address is base plus index
   //   a cycle on  : that byte comes back and lands in the gather word
   //   LAST        : the final byte lands
   //   PUSH        : the stack moves by one layer, or by two for a pair
   //   after PUSH  : reqDone high for one cycle, stack already settled
   // store walk:
   //   accept edge : first write strobe, data and mask launched with it
   //   WR cycles   : one byte per cycle, lowest register first
   //   after last  : reqDone high for one cycle, memory already written
   // reqDone rises n + 2 edges after acceptance for a load of n bytes and
   // n edges after it for a store; a store never moves the stack
   // an unknown type is refused at once: reqBadType and reqDone pulse
   // together one edge later and nothing else moves

   reg  [2:0]    state_q;
   reg  [2:0]    state_d;
   reg  [2:0]    type_q;
   reg  [15:0]   base_q;
   reg  [2:0]    bit_q;
   reg  [2:0]    nBytes_q;
   reg  [1:0]    cnt_q;
   reg  [1:0]    cnt_d;
   reg           capEn_q;
   reg  [1:0]    capIdx_q;
   reg  [31:0]   gath_q;
   reg  [SW-1:0] stack_q;
   wire [SW-1:0] stack_d;
   wire [LW-1:0] newLow;
   wire [LW-1:0] newHigh;
   wire          pushTwo;
   wire          doPush;
   wire          lastByte;
   wire          topAny;
   reg  [2:0]    nBytesReq;
   reg           typeOk;
   wire [31:0]   storeSrc;
   wire [7:0]    storeByte;
   // write side, completion and overflow flag helpers
   wire          refuse;
   wire [2:0]    wrType;
   wire [2:0]    wrBit;
   wire [31:0]   nextTop;
   reg           doneNext;

   // layer views of the flat stack vector
   assign stackTopLayer     = stack_q[LW-1:0];
   assign secondStackLayer  = stack_q[2*LW-1:LW];
   assign deepestStackLayer = stack_q[SW-1:SW-LW];

   // the top pair in narrow mode and the wide top layer share bits 31:0
   assign topDoubleLayer = stack_q[31:0];

   assign reqReady = (state_q == ST_IDLE);

   // byte count of each operand type; unknown codes are refused
   always @* begin
      nBytesReq = `SOF_N_ONE;
      typeOk    = 1'b1;
      case (reqType)
         `SOF_T_BOOL:  nBytesReq = `SOF_N_ONE;
         `SOF_T_BYTE:  nBytesReq = `SOF_N_ONE;
         `SOF_T_WORD:  nBytesReq = `SOF_N_TWO;
         `SOF_T_DWORD: nBytesReq = `SOF_N_FOUR;
         `SOF_T_REAL:  nBytesReq = `SOF_N_FOUR;
         default:      typeOk    = 1'b0;
      endcase
   end

   assign lastByte = ({1'b0, cnt_q} == (nBytes_q - 3'h1));

   // next state; a load ends with one push, a store never touches the stack
   always @* begin
      state_d = state_q;
      cnt_d   = cnt_q;
      case (state_q)
         ST_IDLE: begin
            cnt_d = 2'h0;
            if (reqValid && typeOk) begin
               if (reqStore) begin
                  state_d = ST_WR;
               end else begin
                  state_d = ST_RD;
               end
            end
         end
         ST_RD: begin
            if (lastByte) begin
               state_d = ST_LAST;
            end else begin
               cnt_d = cnt_q + 2'h1;
            end
         end
         ST_LAST: begin
            state_d = ST_PUSH;
         end
         ST_PUSH: begin
            state_d = ST_IDLE;
         end
         ST_WR: begin
            if (lastByte) begin
               state_d = ST_IDLE;
            end else begin
               cnt_d = cnt_q + 2'h1;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // state, counters and the latched request
   always @(posedge mclk) begin
      if (!nrst) begin
         state_q  <= ST_IDLE;
         cnt_q    <= 2'h0;
         type_q   <= `SOF_T_BOOL;
         base_q   <= 16'h0000;
         bit_q    <= 3'h0;
         nBytes_q <= `SOF_N_ONE;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         if (reqReady && reqValid && typeOk) begin
            type_q   <= reqType;
            base_q   <= reqBase;
            bit_q    <= reqBit;
            nBytes_q <= nBytesReq;
         end
      end
   end

   // read data arrives a cycle late, so the byte index is carried along
   always @(posedge mclk) begin
      if (!nrst) begin
         capEn_q  <= 1'b0;
         capIdx_q <= 2'h0;
      end else begin
         capEn_q  <= (state_q == ST_RD);
         capIdx_q <= cnt_q;
      end
   end

   // ascending registers fill ascending bytes of the gather word
   always @(posedge mclk) begin
      if (!nrst) begin
         gath_q <= 32'h00000000;
      end else if (state_q == ST_IDLE) begin
         gath_q <= 32'h00000000;
      end else if (capEn_q) begin
         gath_q[8*capIdx_q +: 8] <= spRdData;
      end
   end

   // format the gathered bytes into one or two new layers
   sof_load_pack #(
      .WIDE     (WIDE)
   ) uPack (
      .opType   (type_q),
      .gathered (gath_q),
      .bitVal   (gath_q[bit_q]),
      .newLow   (newLow),
      .newHigh  (newHigh),
      .pushTwo  (pushTwo)
   );

   assign doPush = (state_q == ST_PUSH);

   // per layer shift: one step, or two for a narrow four-byte value
   genvar i;
   generate
      for (i = 0; i < `SOF_DEPTH; i = i + 1) begin : gLayer
         if (i == 0) begin : gTop
            assign stack_d[LW-1:0] = newLow;
         end else if (i == 1) begin : gSecond
            assign stack_d[2*LW-1:LW] = pushTwo ? newHigh
                                     : stack_q[LW-1:0];
         end else begin : gDeep
            assign stack_d[(i+1)*LW-1:i*LW] = pushTwo
               ? stack_q[(i-1)*LW-1:(i-2)*LW]
               : stack_q[i*LW-1:(i-1)*LW];
         end
      end
   endgenerate

   // deepest layer falls off the end, new data enters the top
   always @(posedge mclk) begin
      if (!nrst) begin
         stack_q <= {SW{1'b0}};
      end else if (doPush) begin
         stack_q <= stack_d;
      end
   end

   // store source: narrow pair or wide layer, lowest byte first; the byte
   // is picked by cnt_d because it is launched one cycle ahead of its use
   assign storeSrc  = stack_q[31:0];
   assign storeByte = storeSrc[8*cnt_d +: 8];
   assign topAny    = |stack_q[LW-1:0];

   // scratchpad strobes come from flops, one byte per cycle
   always @(posedge mclk) begin
      if (!nrst) begin
         spAddr   <= 16'h0000;
         spRdEn   <= 1'b0;
         spWrEn   <= 1'b0;
      end else begin
         spRdEn   <= 1'b0;
         spWrEn   <= 1'b0;
         if (state_d == ST_RD) begin
            spRdEn <= 1'b1;
            spAddr <= (state_q == ST_IDLE) ? reqBase
                    : base_q + {14'h0000, cnt_d};
         end else if (state_d == ST_WR) begin
            spWrEn <= 1'b1;
            spAddr <= (state_q == ST_IDLE) ? reqBase
                    : base_q + {14'h0000, cnt_d};
         end
      end
   end

   // at the accepting edge the latched copies are not loaded yet, so the
   // first write takes type and bit straight from the request
   assign wrType = reqReady ? reqType : type_q;
   assign wrBit  = reqReady ? reqBit : bit_q;

   // data and mask leave with the address of the same byte; a bit store
   // touches its one bit only, the rest of that register survives
   always @(posedge mclk) begin
      if (!nrst) begin
         spWrData <= 8'h00;
         spWrMask <= 8'h00;
      end else begin
         spWrMask <= 8'h00;
         if (state_d == ST_WR) begin
            if (wrType == `SOF_T_BOOL) begin
               spWrData <= {8{topAny}};
               spWrMask <= 8'h01 << wrBit;
            end else begin
               spWrData <= storeByte;
               spWrMask <= 8'hFF;
            end
         end
      end
   end

   // an unknown type is answered, not ignored, so no requester hangs
   assign refuse = reqReady && reqValid && !typeOk;

   // completion: after the push of a load, after the last byte of a
   // store, or straight away for a refused request
   always @* begin
      doneNext = 1'b0;
      case (state_q)
         ST_IDLE: begin
            doneNext = refuse;
         end
         ST_PUSH: begin
            doneNext = 1'b1;
         end
         ST_WR: begin
            doneNext = lastByte;
         end
         default: begin
            doneNext = 1'b0;
         end
      endcase
   end

   // one cycle pulses for the execution unit
   always @(posedge mclk) begin
      if (!nrst) begin
         reqDone    <= 1'b0;
         reqBadType <= 1'b0;
      end else begin
         reqDone    <= doneNext;
         reqBadType <= refuse;
      end
   end

   // overflow patterns of the top pair, or of the wide top layer; taken
   // from the value the stack is about to hold, so a flag changes at the
   // same edge as the layers and never lags them
   assign nextTop = doPush ? stack_d[31:0] : stack_q[31:0];

   always @(posedge mclk) begin
      if (!nrst) begin
         topPosInf <= 1'b0;
         topNegInf <= 1'b0;
      end else begin
         topPosInf <= (nextTop == `SOF_POS_INF);
         topNegInf <= (nextTop == `SOF_NEG_INF);
      end
   end

endmodule

// ===== testbench/sof_scratch_model.sv
// Purpose: byte scratchpad answering the formatter's strobes
// Assumes: read data is due one cycle after the read strobe
// Notes: idle read data toggles so a stale byte is never trusted
`timescale 1ns/1ps

module sof_scratch_model (
   input  wire        mclk,
   input  wire [15:0] spAddr,
   input  wire        spRdEn,
   output reg  [7:0]  spRdData,
   input  wire        spWrEn,
   input  wire [7:0]  spWrData,
   input  wire [7:0]  spWrMask
);
   reg [7:0] mem [0:255];
   wire [7:0] a = spAddr[7:0];
   initial spRdData = 8'h5A;
   // answer a read one cycle on, merge masked write bits
   always @(posedge mclk) begin
      if (spRdEn) begin
         spRdData <= mem[a];
      end else begin
         spRdData <= ~spRdData;
      end
      if (spWrEn) begin
         mem[a] <= (mem[a] & ~spWrMask) | (spWrData & spWrMask);
      end
   end
endmodule

// ===== testbench/sof_formatter_monitor.sv
// Purpose: port checks of the stack operand formatter
// Assumes: one request at a time, stack moves only after acceptance
// Notes: float and pairing checks apply to the narrow variant only, except a_flag_cause, which checks both
`timescale 1ns/1ps
`include "sof_map.vh"

module sof_formatter_monitor #(
   parameter WIDE = 0
) (
   input wire                        mclk,
   input wire                        nrst,
   input wire                        reqValid,
   input wire                        reqReady,
   input wire                        reqStore,
   input wire [2:0]                  reqType,
   input wire [15:0]                 reqBase,
   input wire [2:0]                  reqBit,
   input wire [15:0]                 spAddr,
   input wire                        spWrEn,
   input wire [7:0]                  spWrData,
   input wire [7:0]                  spWrMask,
   input wire [(WIDE ? 32 : 16)-1:0] stackTopLayer,
   input wire [(WIDE ? 32 : 16)-1:0] secondStackLayer,
   input wire [31:0]                 topDoubleLayer,
   input wire                        topPosInf,
   input wire                        topNegInf
);
   reg  [2:0]  typ_q;
   reg         st_q;
   reg  [15:0] base_q;
   wire [7:0]  ofs = spAddr[7:0] - base_q[7:0];
   wire [31:0] src = WIDE ? 32'(stackTopLayer) : topDoubleLayer;
   wire        ld = !st_q;
   // remember the accepted request, its effects land later
   always @(posedge mclk) begin
      if (!nrst) begin
         typ_q <= 3'h7;
         st_q <= 1'b1;
         base_q <= 16'h0000;
      end else if (reqValid && reqReady) begin
         typ_q <= reqType;
         st_q <= reqStore;
         base_q <= reqBase;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   a_pair_layout: assert property (WIDE || {topDoubleLayer} ==
      {secondStackLayer[15:0], stackTopLayer[15:0]}) else $error("pair");
   a_posinf_flag: assert property ((!WIDE && topDoubleLayer ==
      `SOF_POS_INF) |-> ##[0:1] topPosInf) else $error("posinf");
   a_neginf_flag: assert property ((!WIDE && topDoubleLayer ==
      `SOF_NEG_INF) |-> ##[0:1] topNegInf) else $error("neginf");
   a_flag_cause: assert property (topPosInf |-> (topDoubleLayer ==
      `SOF_POS_INF || $past(topDoubleLayer) == `SOF_POS_INF))
      else $error("flag without pattern");
   a_push_shift: assert property (($changed(secondStackLayer) && ld
      && typ_q < `SOF_T_DWORD) |-> secondStackLayer == $past(stackTopLayer))
      else $error("push");
   a_bool_fill: assert property (($changed(stackTopLayer) && ld
      && typ_q == `SOF_T_BOOL) |-> (stackTopLayer == 0 || &stackTopLayer))
      else $error("bool fill");
   a_byte_zero: assert property (($changed(stackTopLayer) && ld
      && typ_q == `SOF_T_BYTE) |-> (stackTopLayer >> 8) == 0)
      else $error("byte fill");
   a_word_zero: assert property (($changed(stackTopLayer) && ld
      && WIDE && typ_q == `SOF_T_WORD) |-> (stackTopLayer >> 16) == 0)
      else $error("word fill");
   a_bool_mask: assert property ((spWrEn && st_q && typ_q ==
      `SOF_T_BOOL) |-> $onehot(spWrMask)) else $error("bool mask");
   a_byte_mask: assert property ((spWrEn && st_q && typ_q !=
      `SOF_T_BOOL) |-> spWrMask == 8'hFF) else $error("byte mask");
   a_bool_write: assert property ((spWrEn && st_q && typ_q ==
      `SOF_T_BOOL) |-> (spWrData & spWrMask) == ({8{|stackTopLayer}}
      & spWrMask)) else $error("bool write");
   a_byte_order: assert property ((spWrEn && st_q && typ_q !=
      `SOF_T_BOOL) |-> spWrData == src[8*ofs[1:0] +: 8])
      else $error("write byte");
   a_write_span: assert property ((spWrEn && st_q && typ_q !=
      `SOF_T_BOOL) |-> ofs < (typ_q == `SOF_T_BYTE ? 1 :
      typ_q == `SOF_T_WORD ? 2 : 4)) else $error("write span");
   c_bool_load: cover property ($changed(stackTopLayer) && &stackTopLayer);
   c_dword_store: cover property (spWrEn && typ_q == `SOF_T_DWORD);
   c_posinf: cover property (topPosInf);
endmodule

bind sof_formatter sof_formatter_monitor #(.WIDE(WIDE)) u_mon (.*);

// ===== testbench/sof_formatter_tb.sv
// Purpose: self-checking bench for both layer-width variants
// Assumes: requests held until reqReady, completion shown by reqDone
// Notes: four-byte types run on the narrow variant only
`timescale 1ns/1ps
`include "sof_map.vh"

module sof_formatter_tb;
   reg         mclk = 1'b0;
   reg         nrst = 1'b0;
   reg  [1:0]  vld = 2'h0;
   reg         reqStore = 1'b0;
   reg  [2:0]  reqType = 3'h0;
   reg  [15:0] reqBase = 16'h0000;
   reg  [2:0]  reqBit = 3'h0;
   wire [1:0]  rdy, dn, re, we, bd;
   reg  [1:0]  badSeen = 2'h0;
   wire [15:0] aN, aW, tN, sN;
   wire [7:0]  rdN, rdW, wdN, wdW, wmN, wmW;
   wire [31:0] tW, sW, dN;
   wire        piN, niN;
   integer     mismatches = 0;
   integer     n_compared = 0;
   always #12.5 mclk = ~mclk;
   sof_formatter #(.WIDE(0)) dut (.mclk(mclk), .nrst(nrst),
      .reqValid(vld[0]), .reqStore(reqStore), .reqType(reqType),
      .reqBase(reqBase), .reqBit(reqBit), .reqReady(rdy[0]),
      .reqDone(dn[0]), .reqBadType(bd[0]), .spAddr(aN), .spRdEn(re[0]),
      .spRdData(rdN), .spWrEn(we[0]), .spWrData(wdN), .spWrMask(wmN),
      .stackTopLayer(tN), .secondStackLayer(sN), .deepestStackLayer(),
      .topDoubleLayer(dN), .topPosInf(piN), .topNegInf(niN));
   sof_formatter #(.WIDE(1)) dutWide (.mclk(mclk), .nrst(nrst),
      .reqValid(vld[1]), .reqStore(reqStore), .reqType(reqType),
      .reqBase(reqBase), .reqBit(reqBit), .reqReady(rdy[1]),
      .reqDone(dn[1]), .reqBadType(bd[1]), .spAddr(aW), .spRdEn(re[1]),
      .spRdData(rdW), .spWrEn(we[1]), .spWrData(wdW), .spWrMask(wmW),
      .stackTopLayer(tW), .secondStackLayer(sW), .deepestStackLayer(),
      .topDoubleLayer(), .topPosInf(), .topNegInf());
   sof_scratch_model pN (.mclk(mclk), .spAddr(aN), .spRdEn(re[0]),
      .spRdData(rdN), .spWrEn(we[0]), .spWrData(wdN), .spWrMask(wmN));
   sof_scratch_model pW (.mclk(mclk), .spAddr(aW), .spRdEn(re[1]),
      .spRdData(rdW), .spWrEn(we[1]), .spWrData(wdW), .spWrMask(wmW));
   task test_done;
      begin
         if (mismatches == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
         end else begin
            $display("RESULT: FAIL");
         end
         $finish;
      end
   endtask
   task chk(input [8*8:1] nm, input [31:0] seen, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task put(input [7:0] a, input [7:0] d);
      begin
         pN.mem[a] = d;
         pW.mem[a] = d;
      end
   endtask
   task mchk(input [7:0] a, input [7:0] exp);
      begin
         chk("mem n", pN.mem[a], exp);
         chk("mem w", pW.mem[a], exp);
      end
   endtask
   // one request to the variants in m; flags sampled mid-cycle
   task req(input [1:0] m, input st, input [2:0] ty, input [7:0] b,
            input [2:0] bt);
      integer i;
      reg [1:0] got, acc;
      begin
         @(posedge mclk);
         #1;
         got = 2'h0;
         badSeen = 2'h0;
         reqStore = st;
         reqType = ty;
         reqBase = {8'h00, b};
         reqBit = bt;
         vld = m;
         for (i = 0; i < 40 && got != m; i = i + 1) begin
            @(negedge mclk);
            acc = vld & rdy;
            got = got | (dn & m);
            badSeen = badSeen | (bd & m);
            @(posedge mclk);
            #1;
            vld = vld & ~acc;
         end
         if (got != m) begin
            mismatches = mismatches + 1;
            test_done;
         end
      end
   endtask
   task t_bool;
      begin
         put(8'h10, 8'h20);
         req(2'h3, 1'b0, `SOF_T_BOOL, 8'h10, 3'h5);
         chk("good", badSeen, 32'h0);
         chk("bool1 n", tN, 32'h0000FFFF);
         chk("bool1 w", tW, 32'hFFFFFFFF);
         req(2'h3, 1'b0, `SOF_T_BOOL, 8'h10, 3'h4);
         chk("bool0 n", tN, 32'h00000000);
         chk("push n", sN, 32'h0000FFFF);
         chk("bool0 w", tW, 32'h00000000);
         chk("push w", sW, 32'hFFFFFFFF);
      end
   endtask
   task t_load;
      begin
         put(8'h20, 8'hA5);
         put(8'h21, 8'h9C);
         req(2'h3, 1'b0, `SOF_T_BYTE, 8'h20, 3'h0);
         chk("byte n", tN, 32'h000000A5);
         chk("byte w", tW, 32'h000000A5);
         req(2'h3, 1'b0, `SOF_T_WORD, 8'h20, 3'h0);
         chk("word n", tN, 32'h00009CA5);
         chk("word w", tW, 32'h00009CA5);
         chk("push2 n", sN, 32'h000000A5);
      end
   endtask
   task t_store;
      begin
         put(8'h51, 8'h22);
         put(8'h54, 8'h33);
         put(8'h56, 8'h00);
         put(8'h57, 8'hFF);
         put(8'h60, 8'h00);
         req(2'h3, 1'b1, `SOF_T_BYTE, 8'h50, 3'h0);
         mchk(8'h50, 8'hA5);
         mchk(8'h51, 8'h22);
         req(2'h3, 1'b1, `SOF_T_WORD, 8'h52, 3'h0);
         mchk(8'h52, 8'hA5);
         mchk(8'h53, 8'h9C);
         mchk(8'h54, 8'h33);
         req(2'h3, 1'b1, `SOF_T_BOOL, 8'h56, 3'h3);
         mchk(8'h56, 8'h08);
         req(2'h3, 1'b0, `SOF_T_BYTE, 8'h60, 3'h0);
         req(2'h3, 1'b1, `SOF_T_BOOL, 8'h57, 3'h2);
         mchk(8'h57, 8'hFB);
      end
   endtask
   // an unknown type is refused and leaves both stacks alone
   task t_bad;
      begin
         req(2'h3, 1'b0, 3'h7, 8'h10, 3'h0);
         chk("bad", badSeen, 32'h3);
         chk("keep n", tN, 32'h00000000);
         chk("keep w", tW, 32'h00000000);
      end
   endtask
   task t_dword;
      integer i;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            put(8'(8'h30 + i), 8'(`SOF_POS_INF >> (8 * i)));
            put(8'(8'h34 + i), 8'(`SOF_NEG_INF >> (8 * i)));
         end
         req(2'h1, 1'b0, `SOF_T_DWORD, 8'h30, 3'h0);
         chk("dword", dN, `SOF_POS_INF);
         chk("high", sN, 32'h00007F80);
         chk("posinf", piN, 32'h1);
         req(2'h1, 1'b1, `SOF_T_DWORD, 8'h40, 3'h0);
         for (i = 0; i < 4; i = i + 1) begin
            chk("dst", pN.mem[8'h40 + i], 8'(`SOF_POS_INF >> (8 * i)));
         end
         req(2'h1, 1'b0, `SOF_T_REAL, 8'h34, 3'h0);
         chk("neginf", niN, 32'h1);
         chk("posclr", piN, 32'h0);
      end
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      #1;
      nrst = 1'b1;
      t_bool;
      t_load;
      t_store;
      t_bad;
      t_dword;
      test_done;
   end
endmodule
